// ### logic/ddr2ci_top.sv
// control pin interface of a ddr2 memory device
`include "ddr2ci_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ddr2ci_top (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic diff_clock_true_in,
    input wire logic diff_clock_comp_in,
    input wire logic clock_gate_in,
    input wire logic chip_select_n_in,
    input wire logic row_strobe_n_in,
    input wire logic column_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic [`DDR2CI_BANK_W-1:0] bank_in,
    input wire logic [`DDR2CI_ADDR_W-1:0] address_in,
    input wire logic termination_control_in,
    input wire logic odt_disable_in,
    input wire logic org_x8_in,
    input wire logic mask_is_strobe_in,
    input wire logic [`DDR2CI_DQ_W-1:0] dq_in,
    input wire logic lower_data_strobe_in,
    input wire logic upper_data_strobe_in,
    input wire logic lower_write_mask_in,
    input wire logic upper_write_mask_in,
    input wire logic rd_valid_in,
    input wire logic [2*`DDR2CI_DQ_W-1:0] rd_data_in,
    output logic [`DDR2CI_DQ_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic read_only_strobe_out,
    output logic read_only_strobe_oe_out,
    output var ddr2ci_pkg::ddr2ci_cmd_s_t cmd_out,
    output logic cmd_valid_out,
    output var ddr2ci_pkg::ddr2ci_wr_word_t wr_word_out,
    output logic wr_valid_out,
    output var ddr2ci_pkg::ddr2ci_pwr_t pwr_state_out,
    output logic internal_clk_run_out,
    output logic cmd_buf_en_out,
    output logic clk_buf_en_out,
    output logic termination_en_out,
    output logic [`DDR2CI_BANKS-1:0] bank_open_out
);
    function automatic ddr2ci_pkg::ddr2ci_cmd_t decode_cmd(input logic cs_n, input logic ras_n,
        input logic cas_n, input logic we_n);
        if (cs_n) begin
            decode_cmd = ddr2ci_pkg::DDR2CI_CMD_NOP;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h3: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_ACT;
                3'h5: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_RD;
                3'h4: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_WR;
                3'h2: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_PRE;
                3'h1: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_REF;
                3'h0: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_MRS;
                3'h6: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_BST;
                default: decode_cmd = ddr2ci_pkg::DDR2CI_CMD_NOP;
            endcase
        end
    endfunction : decode_cmd

    // two-stage synchronisers for the memory bus pins, not for odt_disable_in, org_x8_in or mask_is_strobe_in
    localparam int SYNC_W = 2 + 1 + 4 + `DDR2CI_BANK_W + `DDR2CI_ADDR_W + 1 + `DDR2CI_DQ_W + 4;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    assign pins_raw = {diff_clock_true_in, diff_clock_comp_in, clock_gate_in, chip_select_n_in,
        row_strobe_n_in, column_strobe_n_in, write_strobe_n_in, bank_in, address_in,
        termination_control_in, dq_in, lower_data_strobe_in, upper_data_strobe_in,
        lower_write_mask_in, upper_write_mask_in};
    always_ff @(posedge core_clk_in) begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
    end

    logic ck_t;
    logic ck_c;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`DDR2CI_BANK_W-1:0] ba;
    logic [`DDR2CI_ADDR_W-1:0] addr;
    logic termination_control;
    logic [`DDR2CI_DQ_W-1:0] dq;
    logic [1:0] strobe;
    logic [1:0] mask;
    assign {ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_control, dq, strobe[0], strobe[1],
        mask[0], mask[1]} = sync2_q;

    // clock crossing detection
    logic ck_t_q;
    logic ck_c_q;
    logic [1:0] strobe_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ck_t_q <= 1'b0;
            ck_c_q <= 1'b1;
            strobe_q <= 2'h0;
        end else begin
            ck_t_q <= ck_t;
            ck_c_q <= ck_c;
            strobe_q <= strobe;
        end
    end
    logic ck_rise;
    logic ck_fall;
    assign ck_rise = ck_t && !ck_t_q && !ck_c;
    assign ck_fall = !ck_t && ck_t_q && ck_c;

    // power state
    ddr2ci_pkg::ddr2ci_pwr_t pwr_q;
    logic running;
    assign running = (pwr_q == ddr2ci_pkg::DDR2CI_PWR_RUN);
    ddr2ci_pkg::ddr2ci_cmd_t cmd_now;
    assign cmd_now = decode_cmd(cs_n, ras_n, cas_n, we_n);
    logic [`DDR2CI_BANKS-1:0] open_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pwr_q <= ddr2ci_pkg::DDR2CI_PWR_RUN;
        end else begin
            case (pwr_q)
                ddr2ci_pkg::DDR2CI_PWR_RUN: begin
                    if (ck_rise && !cke) begin
                        if (open_q != '0) begin
                            pwr_q <= ddr2ci_pkg::DDR2CI_PWR_ACT_PD;
                        end else if (cmd_now == ddr2ci_pkg::DDR2CI_CMD_REF) begin
                            pwr_q <= ddr2ci_pkg::DDR2CI_PWR_SELF_REF;
                        end else begin
                            pwr_q <= ddr2ci_pkg::DDR2CI_PWR_PRE_PD;
                        end
                    end
                end
                ddr2ci_pkg::DDR2CI_PWR_PRE_PD, ddr2ci_pkg::DDR2CI_PWR_ACT_PD: begin
                    if (ck_rise && cke) begin
                        pwr_q <= ddr2ci_pkg::DDR2CI_PWR_RUN;
                    end
                end
                ddr2ci_pkg::DDR2CI_PWR_SELF_REF: begin
                    if (cke) begin
                        pwr_q <= ddr2ci_pkg::DDR2CI_PWR_RUN;
                    end
                end
                default: pwr_q <= ddr2ci_pkg::DDR2CI_PWR_RUN;
            endcase
        end
    end

    // command capture, ignored outside run state
    logic cmd_take;
    assign cmd_take = ck_rise && cke && running;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cmd_valid_out <= 1'b0;
            cmd_out <= '0;
        end else begin
            cmd_valid_out <= cmd_take && (cmd_now != ddr2ci_pkg::DDR2CI_CMD_NOP);
            if (cmd_take) begin
                cmd_out.op <= cmd_now;
                cmd_out.bank <= ba;
                cmd_out.addr <= addr;
                cmd_out.precharge_all <= (cmd_now == ddr2ci_pkg::DDR2CI_CMD_PRE) &&
                    addr[`DDR2CI_AP_BIT];
            end
        end
    end

    // open row tracking per bank
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            open_q <= '0;
        end else if (cmd_take) begin
            if (cmd_now == ddr2ci_pkg::DDR2CI_CMD_ACT) begin
                open_q[ba] <= 1'b1;
            end else if (cmd_now == ddr2ci_pkg::DDR2CI_CMD_PRE) begin
                if (addr[`DDR2CI_AP_BIT]) begin
                    open_q <= '0;
                end else begin
                    open_q[ba] <= 1'b0;
                end
            end
        end
    end

    // write window and masked data capture
    logic [`DDR2CI_CNT_W-1:0] wr_left_q;
    logic [1:0] strobe_edge;
    assign strobe_edge = (strobe ^ strobe_q) & {2{running}};
    logic lane_mask_used;
    assign lane_mask_used = !(org_x8_in && mask_is_strobe_in);
    logic [1:0] lane_keep;
    always_comb begin
        lane_keep = 2'h0;
        for (int i = 0; i < 2; i++) begin
            lane_keep[i] = strobe_edge[i] && !(mask[i] && lane_mask_used);
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wr_left_q <= '0;
            wr_valid_out <= 1'b0;
            wr_word_out <= '0;
        end else begin
            wr_valid_out <= 1'b0;
            if (cmd_take && cmd_now == ddr2ci_pkg::DDR2CI_CMD_WR) begin
                wr_left_q <= `DDR2CI_BURST_WORDS;
            end else if (wr_left_q != '0 && strobe_edge != 2'h0) begin
                wr_left_q <= wr_left_q - 1'b1;
                wr_valid_out <= 1'b1;
                wr_word_out.data <= dq;
                wr_word_out.byte_en <= lane_keep;
            end
        end
    end

    // read data on both crossings
    logic [2*`DDR2CI_DQ_W-1:0] rd_hold_q;
    logic rd_busy_q;
    logic rd_second_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rd_hold_q <= '0;
            rd_busy_q <= 1'b0;
            rd_second_q <= 1'b0;
            dq_out <= '0;
            dq_oe_out <= 1'b0;
            read_only_strobe_out <= 1'b0;
            read_only_strobe_oe_out <= 1'b0;
        end else if (!running) begin
            rd_busy_q <= 1'b0;
            rd_second_q <= 1'b0;
            dq_oe_out <= 1'b0;
            read_only_strobe_oe_out <= 1'b0;
        end else begin
            if (rd_valid_in && !rd_busy_q) begin
                rd_hold_q <= rd_data_in;
                rd_busy_q <= 1'b1;
            end
            if (ck_rise && rd_busy_q && !rd_second_q) begin
                dq_out <= rd_hold_q[`DDR2CI_DQ_W-1:0];
                dq_oe_out <= 1'b1;
                rd_second_q <= 1'b1;
                read_only_strobe_out <= 1'b1;
                read_only_strobe_oe_out <= org_x8_in && mask_is_strobe_in;
            end else if (ck_fall && rd_second_q) begin
                dq_out <= rd_hold_q[2*`DDR2CI_DQ_W-1:`DDR2CI_DQ_W];
                rd_second_q <= 1'b0;
                rd_busy_q <= 1'b0;
                read_only_strobe_out <= 1'b0;
            end else if (ck_rise && !rd_busy_q) begin
                dq_oe_out <= 1'b0;
                read_only_strobe_oe_out <= 1'b0;
            end
        end
    end

    // buffer enables and termination
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            internal_clk_run_out <= 1'b1;
            cmd_buf_en_out <= 1'b1;
            clk_buf_en_out <= 1'b1;
            termination_en_out <= 1'b0;
            pwr_state_out <= ddr2ci_pkg::DDR2CI_PWR_RUN;
            bank_open_out <= '0;
        end else begin
            internal_clk_run_out <= running;
            cmd_buf_en_out <= running;
            clk_buf_en_out <= (pwr_q != ddr2ci_pkg::DDR2CI_PWR_SELF_REF);
            if (ck_rise) begin
                termination_en_out <= termination_control && !odt_disable_in && running;
            end
            pwr_state_out <= pwr_q;
            bank_open_out <= open_q;
        end
    end
endmodule : ddr2ci_top
`default_nettype wire

// ### include/ddr2ci_defs.svh
// constants for the ddr2 control pin interface
`ifndef DDR2CI_DEFS_SVH
`define DDR2CI_DEFS_SVH
`define DDR2CI_ADDR_W 13
`define DDR2CI_BANK_W 3
`define DDR2CI_BANKS 8
`define DDR2CI_DQ_W 16
`define DDR2CI_LANE_W 8
`define DDR2CI_AP_BIT 10
`define DDR2CI_BURST_WORDS 4'h8
`define DDR2CI_CNT_W 4
`define DDR2CI_LO_LANE 0
`define DDR2CI_HI_LANE 1
`endif

// ### include/ddr2ci_pkg.sv
// types for the ddr2 control pin interface
`default_nettype none
`include "ddr2ci_defs.svh"
package ddr2ci_pkg;
    typedef enum logic [2:0] {
        DDR2CI_CMD_NOP = 3'h0,
        DDR2CI_CMD_ACT = 3'h1,
        DDR2CI_CMD_RD = 3'h2,
        DDR2CI_CMD_WR = 3'h3,
        DDR2CI_CMD_PRE = 3'h4,
        DDR2CI_CMD_REF = 3'h5,
        DDR2CI_CMD_MRS = 3'h6,
        DDR2CI_CMD_BST = 3'h7
    } ddr2ci_cmd_t;
    typedef enum logic [1:0] {
        DDR2CI_PWR_RUN = 2'h0,
        DDR2CI_PWR_PRE_PD = 2'h1,
        DDR2CI_PWR_ACT_PD = 2'h2,
        DDR2CI_PWR_SELF_REF = 2'h3
    } ddr2ci_pwr_t;
    typedef struct packed {
        ddr2ci_cmd_t op;
        logic [`DDR2CI_BANK_W-1:0] bank;
        logic [`DDR2CI_ADDR_W-1:0] addr;
        logic precharge_all;
    } ddr2ci_cmd_s_t;
    typedef struct packed {
        logic [`DDR2CI_DQ_W-1:0] data;
        logic [1:0] byte_en;
    } ddr2ci_wr_word_t;
endpackage : ddr2ci_pkg
`default_nettype wire

// ### tb/ddr2ci_sva.sv
// port assertions for the ddr2 control pin block
`include "ddr2ci_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ddr2ci_sva (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic odt_disable_in,
    input wire logic org_x8_in,
    input wire logic mask_is_strobe_in,
    input wire ddr2ci_pkg::ddr2ci_cmd_s_t cmd_out,
    input wire logic cmd_valid_out,
    input wire logic read_only_strobe_oe_out,
    input wire ddr2ci_pkg::ddr2ci_pwr_t pwr_state_out,
    input wire logic internal_clk_run_out,
    input wire logic cmd_buf_en_out,
    input wire logic clk_buf_en_out,
    input wire logic termination_en_out,
    input wire logic [`DDR2CI_BANKS-1:0] bank_open_out
);
    wire logic run = pwr_state_out == ddr2ci_pkg::DDR2CI_PWR_RUN;
    wire logic act_pd = pwr_state_out == ddr2ci_pkg::DDR2CI_PWR_ACT_PD;
    wire logic sr = pwr_state_out == ddr2ci_pkg::DDR2CI_PWR_SELF_REF;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    chk_cmd_spacing: assert property (cmd_valid_out |=> !cmd_valid_out [*6])
        else $error("commands too close");
    chk_cmd_in_run: assert property (cmd_valid_out |-> run)
        else $error("command outside run");
    chk_pd_buffers: assert property (!run && !sr |-> !cmd_buf_en_out && clk_buf_en_out
        && !internal_clk_run_out)
        else $error("power-down buffers wrong");
    chk_run_buffers: assert property (run |-> cmd_buf_en_out && clk_buf_en_out
        && internal_clk_run_out)
        else $error("run buffers wrong");
    chk_sr_buffers: assert property (sr |-> !clk_buf_en_out && !internal_clk_run_out)
        else $error("self refresh buffers wrong");
    chk_pd_kind: assert property (!run |-> act_pd == (bank_open_out != '0))
        else $error("power-down kind wrong");
    chk_pre_all: assert property (cmd_valid_out && cmd_out.op == ddr2ci_pkg::DDR2CI_CMD_PRE
        |-> cmd_out.precharge_all == cmd_out.addr[`DDR2CI_AP_BIT])
        else $error("precharge all flag wrong");
    chk_term_off: assert property ($rose(termination_en_out) |-> !$past(odt_disable_in))
        else $error("termination while disabled");
    chk_mask_pin: assert property (read_only_strobe_oe_out |-> org_x8_in && mask_is_strobe_in)
        else $error("mask pin driven");
endmodule : ddr2ci_sva
bind ddr2ci_top ddr2ci_sva u_sva (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .odt_disable_in(odt_disable_in),
    .org_x8_in(org_x8_in),
    .mask_is_strobe_in(mask_is_strobe_in),
    .cmd_out(cmd_out),
    .cmd_valid_out(cmd_valid_out),
    .read_only_strobe_oe_out(read_only_strobe_oe_out),
    .pwr_state_out(pwr_state_out),
    .internal_clk_run_out(internal_clk_run_out),
    .cmd_buf_en_out(cmd_buf_en_out),
    .clk_buf_en_out(clk_buf_en_out),
    .termination_en_out(termination_en_out),
    .bank_open_out(bank_open_out)
);
`default_nettype wire

// ### tb/ddr2ci_ctrl_model.sv
// controller model: memory clock and command pins
`timescale 1ns/1ps
`default_nettype none
module ddr2ci_ctrl_model (
    input wire logic core_clk_in,
    output logic ck_out,
    output logic ck_n_out,
    output logic cs_n_out,
    output logic [2:0] rcw_out,
    output logic [2:0] bank_out,
    output logic [12:0] addr_out
);
    logic ck_en = 1'b1;
    logic [1:0] ph = 2'h0;
    initial begin
        ck_out = 1'b0;
        cs_n_out = 1'b1;
        rcw_out = 3'h7;
        bank_out = 3'h0;
        addr_out = 13'h0;
    end
    // memory clock, stopped only for self refresh
    always @(negedge core_clk_in) begin
        if (ck_en) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) ck_out <= ~ck_out;
        end
    end
    assign ck_n_out = ~ck_out;
    // pins change after a fall, held across the rise
    task automatic issue(input logic cs_n, input logic [2:0] c, input logic [2:0] b,
        input logic [12:0] a);
        @(negedge ck_out);
        {cs_n_out, rcw_out, bank_out, addr_out} = {cs_n, c, b, a};
        @(negedge ck_out);
        {cs_n_out, rcw_out, addr_out} = {1'b1, 3'($urandom), ~a};
    endtask : issue
endmodule : ddr2ci_ctrl_model
`default_nettype wire

// ### tb/tb_ddr2_control_pin_interface.sv
// self-checking bench for the ddr2 control pin block
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_control_pin_interface;
    logic core_clk_in, reset_in, clock_gate_in, termination_control_in, odt_disable_in;
    logic org_x8_in, mask_is_strobe_in, lower_data_strobe_in, upper_data_strobe_in;
    logic lower_write_mask_in, upper_write_mask_in, rd_valid_in, diff_clock_true_in;
    logic diff_clock_comp_in, chip_select_n_in, row_strobe_n_in, column_strobe_n_in;
    logic write_strobe_n_in, dq_oe_out, read_only_strobe_out, read_only_strobe_oe_out;
    logic cmd_valid_out, wr_valid_out, internal_clk_run_out, cmd_buf_en_out;
    logic clk_buf_en_out, termination_en_out;
    logic [2:0] bank_in;
    logic [12:0] address_in;
    logic [15:0] dq_in, dq_out;
    logic [31:0] rd_data_in;
    logic [7:0] bank_open_out;
    ddr2ci_pkg::ddr2ci_cmd_s_t cmd_out, ec, cq[$];
    ddr2ci_pkg::ddr2ci_wr_word_t wr_word_out, ew, wq[$];
    ddr2ci_pkg::ddr2ci_pwr_t pwr_state_out;
    logic [15:0] rq[$];
    logic [2:0] op_of [8] = '{3'h6, 3'h5, 3'h4, 3'h1, 3'h3, 3'h2, 3'h7, 3'h0};
    int n_errors = 0;
    int n_tests = 0;

    ddr2ci_ctrl_model u_ctrl (.core_clk_in, .ck_out(diff_clock_true_in),
        .ck_n_out(diff_clock_comp_in), .cs_n_out(chip_select_n_in),
        .rcw_out({row_strobe_n_in, column_strobe_n_in, write_strobe_n_in}),
        .bank_out(bank_in), .addr_out(address_in));
    ddr2ci_top u_dut (.*);

    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic check(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc

    task automatic cmd(input logic cs_n, input logic [2:0] c, input logic [2:0] b,
        input logic [12:0] a, input logic take);
        if (take && !cs_n && c != 3'h7) begin
            cq.push_back(ddr2ci_pkg::ddr2ci_cmd_s_t'({op_of[c], b, a, a[10]}));
        end
        u_ctrl.issue(cs_n, c, b, a);
    endtask : cmd

    task automatic burst(input logic ms);
        logic [1:0] keep;
        org_x8_in = ms;
        mask_is_strobe_in = ms;
        cmd(1'b0, 3'h4, 3'h0, 13'h0, 1'b1);
        for (int k = 0; k < 9; k++) begin
            dq_in = 16'($urandom);
            {upper_write_mask_in, lower_write_mask_in} = 2'($urandom);
            keep = ms ? 2'h3 : ~{upper_write_mask_in, lower_write_mask_in};
            if (k < 8) wq.push_back({dq_in, keep});
            cyc(3);
            lower_data_strobe_in = ~lower_data_strobe_in;
            upper_data_strobe_in = ~upper_data_strobe_in;
            cyc(4);
        end
    endtask : burst

    task automatic pw(input logic g, input ddr2ci_pkg::ddr2ci_pwr_t s);
        clock_gate_in = g;
        cyc(20);
        check(pwr_state_out === s, "power state");
        check(internal_clk_run_out === (s == ddr2ci_pkg::DDR2CI_PWR_RUN), "internal clock");
    endtask : pw

    task automatic give_verdict;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    always @(negedge core_clk_in) begin
        if (cmd_valid_out === 1'b1) begin
            ec = cq.size() > 0 ? cq.pop_front() : ~cmd_out;
            check(cmd_out[19:1] === ec[19:1], "command");
        end
        if (wr_valid_out === 1'b1) begin
            ew = wq.size() > 0 ? wq.pop_front() : ~wr_word_out;
            check(wr_word_out === ew, "write word");
        end
    end

    always @(diff_clock_true_in) begin
        if (dq_oe_out === 1'b1 && rq.size() > 0) begin
            check(read_only_strobe_oe_out === 1'b1, "read strobe enable");
            check(read_only_strobe_out === (rq.size() == 2), "read strobe");
            check(dq_out === rq.pop_front(), "read word");
        end
    end

    initial begin
        void'($urandom(12));
        reset_in = 1'b1;
        clock_gate_in = 1'b1;
        {termination_control_in, odt_disable_in, org_x8_in, mask_is_strobe_in} = 4'h0;
        {lower_data_strobe_in, upper_data_strobe_in, lower_write_mask_in, upper_write_mask_in} = 4'h0;
        rd_valid_in = 1'b0;
        dq_in = 16'h0;
        rd_data_in = 32'h0;
        repeat (12) @(posedge core_clk_in);
        cyc(1);
        reset_in = 1'b0;
        cyc(4);
        for (int i = 0; i < 16; i++) cmd(i[3], i[2:0], 3'($urandom), 13'($urandom), 1'b1);
        cmd(1'b0, 3'h2, 3'h0, 13'h0400, 1'b1);
        cmd(1'b0, 3'h3, 3'h3, 13'($urandom), 1'b1);
        cyc(8);
        check(bank_open_out === 8'h08, "bank open");
        burst(1'b0);
        burst(1'b1);
        rd_data_in = $urandom;
        rq.push_back(rd_data_in[15:0]);
        rq.push_back(rd_data_in[31:16]);
        rd_valid_in = 1'b1;
        cyc(1);
        rd_valid_in = 1'b0;
        cyc(40);
        {org_x8_in, mask_is_strobe_in, termination_control_in} = 3'h1;
        cyc(20);
        check(termination_en_out === 1'b1, "termination on");
        odt_disable_in = 1'b1;
        cyc(20);
        check(termination_en_out === 1'b0, "termination ignored");
        {termination_control_in, odt_disable_in} = 2'h0;
        pw(1'b0, ddr2ci_pkg::DDR2CI_PWR_ACT_PD);
        cmd(1'b0, 3'h3, 3'h5, 13'h0, 1'b0);
        pw(1'b1, ddr2ci_pkg::DDR2CI_PWR_RUN);
        cmd(1'b0, 3'h2, 3'h0, 13'h0400, 1'b1);
        pw(1'b0, ddr2ci_pkg::DDR2CI_PWR_PRE_PD);
        pw(1'b1, ddr2ci_pkg::DDR2CI_PWR_RUN);
        fork
            cmd(1'b0, 3'h1, 3'h0, 13'h0, 1'b0);
            begin
                @(negedge diff_clock_true_in);
                clock_gate_in = 1'b0;
            end
        join
        cyc(16);
        check(pwr_state_out === ddr2ci_pkg::DDR2CI_PWR_SELF_REF, "self refresh");
        u_ctrl.ck_en = 1'b0;
        pw(1'b1, ddr2ci_pkg::DDR2CI_PWR_RUN);
        u_ctrl.ck_en = 1'b1;
        cyc(20);
        check(cq.size() == 0 && wq.size() == 0 && rq.size() == 0, "results missing");
        give_verdict();
    end

    // run needs about 15 us
    initial begin
        #400000;
        n_errors++;
        give_verdict();
    end
endmodule : tb_ddr2_control_pin_interface
`default_nettype wire
